// ---- src/sr_seq.sv ----
// Purpose: self refresh entry/exit sequencing inside the memory device
// Assumes: pins and reset_n come from CK domain equal to clk_i
// Notes:   controller obligations are not policed, only observed
//
// Summary of operation
// - device accepts self refresh entry in any rate mode, any refresh count
// - entry decoded: cs, ras, cas, cke low; we and act high
// - termination forced off in self refresh, restored on exit
// - dll disabled at entry, re-enabled with reset at exit when dll on
// - in self refresh only cke, cs and reset matter; internal timer refreshes
// - exit decoded as cke high with deselect
// - on-the-fly modes sample bank group bit zero per refresh
`timescale 1ns/10ps
module sr_seq #(
  parameter int EXIT_CYC     = 72,
  parameter int DLL_LOCK_CYC = 1024,
  parameter int RFC_CYC      = 70,
  parameter int SR_TICK_CYC  = 1560
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // memory pins
  input  wire sr_pkg::cmd_s cmd_i,
  input  wire logic        odt_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // device state
  output logic             odt_on_o,
  output logic             dll_en_o,
  output logic             dll_rst_o,
  output logic             clk_gate_o,
  output logic             int_refresh_o,
  output logic             refresh_o,
  output logic             refresh_fast_o
);

  // ----------------------------------------------------------------------
  // pin synchroniser (first stage read only by the second)
  // ----------------------------------------------------------------------
  sr_pkg::cmd_s s1_q, s2_q;
  logic         o1_q, o2_q;
  always_ff @(posedge clk_i) begin
    s1_q <= cmd_i;
    s2_q <= s1_q;
    o1_q <= odt_i;
    o2_q <= o1_q;
  end

  logic is_sre, is_srx, is_ref;
  assign is_sre = !s2_q.cke && !s2_q.cs_n && !s2_q.ras_n && !s2_q.cas_n
                  && s2_q.we_n && s2_q.act_n;
  assign is_srx = s2_q.cke && s2_q.cs_n;
  assign is_ref = s2_q.cke && !s2_q.cs_n && s2_q.act_n && !s2_q.ras_n
                  && !s2_q.cas_n && s2_q.we_n;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [4:0]  ctrl_q, ctrl_d;
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [15:0] entries_q, entries_d;
  sr_pkg::sr_state_e st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic [31:0] tick_q, tick_d;
  logic        ref_q, ref_d, fast_q, fast_d, iref_q, iref_d;
  logic        wr;

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;

  always_comb begin
    ctrl_d  = ctrl_q;
    ack_d   = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d  = 32'h0000_0000;
    if (wr && wb_adr_i == sr_pkg::CTRL_OFS && wb_sel_i[0]) begin
      ctrl_d = wb_dat_i[4:0];
    end
    unique case (wb_adr_i)
      sr_pkg::CTRL_OFS:   rdat_d = {27'h0, ctrl_q};
      sr_pkg::STATUS_OFS: rdat_d = {28'h0, st_q};
      sr_pkg::COUNT_OFS:  rdat_d = {16'h0, entries_q};
      default:            rdat_d = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // self refresh state machine
  // ----------------------------------------------------------------------
  logic on_the_fly_rate;
  assign on_the_fly_rate = ctrl_q[2];

  always_comb begin
    st_d      = st_q;
    cnt_d     = cnt_q;
    tick_d    = tick_q;
    entries_d = entries_q;
    ref_d     = 1'b0;
    fast_d    = 1'b0;
    iref_d    = 1'b0;
    unique case (st_q)
      sr_pkg::ST_IDLE: begin
        if (is_ref) begin
          ref_d  = 1'b1;
          fast_d = on_the_fly_rate ? s2_q.bg0 : (ctrl_q[1:0] != 2'b00);
        end
        if (is_sre) begin
          st_d      = sr_pkg::ST_SELF;
          tick_d    = 32'h0;
          entries_d = entries_q + 16'h0001;
        end
      end
      sr_pkg::ST_SELF: begin
        // internal timer keeps the array alive with clock gated
        tick_d = (tick_q == 32'(SR_TICK_CYC - 1)) ? 32'h0 : tick_q + 32'h1;
        iref_d = (tick_q == 32'(SR_TICK_CYC - 1));
        if (is_srx) begin
          st_d  = sr_pkg::ST_EXIT;
          cnt_d = 32'h0;
        end
      end
      sr_pkg::ST_EXIT: begin
        // refresh in flight completes before the exit delay ends
        cnt_d = cnt_q + 32'h1;
        if (cnt_q == 32'(EXIT_CYC - 1)) begin
          st_d = sr_pkg::ST_LOCK;
        end
      end
      sr_pkg::ST_LOCK: begin
        cnt_d = cnt_q + 32'h1;
        if (cnt_q == 32'(DLL_LOCK_CYC - 1)) begin
          st_d = sr_pkg::ST_IDLE;
        end else if (is_sre) begin
          st_d = sr_pkg::ST_SELF;
          tick_d = 32'h0;
          entries_d = entries_q + 16'h0001;
        end
        if (is_ref) begin
          ref_d  = 1'b1;
          fast_d = on_the_fly_rate ? s2_q.bg0 : (ctrl_q[1:0] != 2'b00);
        end
      end
      default: st_d = sr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q    <= sr_pkg::CTRL_RST;
      ack_q     <= 1'b0;
      rdat_q    <= 32'h0000_0000;
      st_q      <= sr_pkg::ST_IDLE;
      cnt_q     <= 32'h0;
      tick_q    <= 32'h0;
      entries_q <= 16'h0000;
      ref_q     <= 1'b0;
      fast_q    <= 1'b0;
      iref_q    <= 1'b0;
      odt_on_o  <= 1'b0;
      dll_en_o  <= 1'b0;
      dll_rst_o <= 1'b0;
      clk_gate_o <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      ack_q     <= ack_d;
      rdat_q    <= rdat_d;
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      tick_q    <= tick_d;
      entries_q <= entries_d;
      ref_q     <= ref_d;
      fast_q    <= fast_d;
      iref_q    <= iref_d;
      odt_on_o  <= (st_d != sr_pkg::ST_SELF) && o2_q;
      dll_en_o  <= ctrl_q[sr_pkg::DLLON_BIT] && (st_d != sr_pkg::ST_SELF);
      dll_rst_o <= ctrl_q[sr_pkg::DLLON_BIT] && (st_q == sr_pkg::ST_SELF)
                   && (st_d == sr_pkg::ST_EXIT);
      clk_gate_o <= (st_d == sr_pkg::ST_SELF);
    end
  end

  assign wb_ack_o       = ack_q;
  assign wb_dat_o       = rdat_q;
  assign refresh_o      = ref_q;
  assign refresh_fast_o = fast_q;
  assign int_refresh_o  = iref_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  AST_SRE_ENTERS: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == sr_pkg::ST_IDLE && is_sre) |=> st_q == sr_pkg::ST_SELF)
    else $error("entry not taken");
  AST_SRX_EXITS: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == sr_pkg::ST_SELF && is_srx) |=> st_q == sr_pkg::ST_EXIT)
    else $error("exit not taken");
  AST_ODT_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == sr_pkg::ST_SELF |-> !odt_on_o)
    else $error("odt on in self refresh");
  AST_DLL_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == sr_pkg::ST_SELF |-> !dll_en_o)
    else $error("dll on in self refresh");
  AST_DLL_RST: assert property (@(posedge clk_i) disable iff (rst_i)
    ($rose(st_q == sr_pkg::ST_EXIT) && ctrl_q[sr_pkg::DLLON_BIT]) |-> dll_rst_o)
    else $error("no dll reset at exit");
  AST_IGNORE: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == sr_pkg::ST_SELF |-> !refresh_o)
    else $error("command accepted in self refresh");
  AST_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
    st_q == sr_pkg::ST_SELF |-> clk_gate_o)
    else $error("clock not gated");
  AST_OTF: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_q == sr_pkg::ST_IDLE && is_ref && on_the_fly_rate) |=> refresh_fast_o == $past(s2_q.bg0))
    else $error("bg0 not sampled");

endmodule : sr_seq

// ---- src/sr_pkg.sv ----
// Purpose: shared constants and carriers for the self refresh sequencer
// Assumes: 200 MHz core clock, command pins already sampled on CK
// Notes:   register offsets are byte addresses on a 32-bit classic Wishbone
package sr_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] COUNT_OFS  = 8'h08;

  // ctrl fields
  localparam int         RATE_LSB   = 0;
  localparam int         TCR_BIT    = 3;
  localparam int         DLLON_BIT  = 4;
  localparam logic [4:0] CTRL_RST   = 5'h10;

  // refresh_rate_field encodings
  localparam logic [2:0] RATE_1X     = 3'h0;
  localparam logic [2:0] RATE_2X     = 3'h1;
  localparam logic [2:0] RATE_4X     = 3'h2;
  localparam logic [2:0] RATE_OTF_2X = 3'h5;
  localparam logic [2:0] RATE_OTF_4X = 3'h6;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CLK_PS             = 5000;
  localparam int FAST_MARGIN_NS     = 10;
  localparam int FAST_MARGIN_CYC    = (FAST_MARGIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CLK_STOP_NCK       = 8;

  // command pins sampled at a CK rising edge
  typedef struct packed {
    logic       cke;
    logic       cs_n;
    logic       act_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic       bg0;
  } cmd_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SELF = 4'b0010,
    ST_EXIT = 4'b0100,
    ST_LOCK = 4'b1000
  } sr_state_e;

endpackage : sr_pkg

// ---- sim/sr_ctrl_model.sv ----
// Purpose: controller model driving the command pins and the termination pin
// Assumes: one clock shared with the device, all counts in clock cycles
// Notes:   pins churn while cke is low, so ignored inputs really vary
`timescale 1ns/10ps
module sr_ctrl_model #(
  parameter int EXIT_CYC = 4,
  parameter int RFC_CYC  = 4
) (
  // clock
  input  wire logic    clk_i,
  // pins
  output sr_pkg::cmd_s cmd_o,
  output logic         odt_o
);
  // ----------------------------------------------------------------------
  // command tasks
  // ----------------------------------------------------------------------
  initial begin
    cmd_o = 7'h7E;
    odt_o = 1'b0;
  end

  task automatic des(input int n);
    repeat (n) begin
      @(posedge clk_i);
      cmd_o <= {2'b11, 5'($urandom)};
    end
  endtask : des

  task automatic refresh(input logic bg);
    @(posedge clk_i);
    cmd_o <= {6'h29, bg};
    des(RFC_CYC);
  endtask : refresh

  task automatic enter();
    @(posedge clk_i);
    cmd_o <= {6'h09, 1'b0};
    odt_o <= 1'b1;
  endtask : enter

  // cs kept low three cycles, then random; the other ignored pins are random from the first cycle
  task automatic stay(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      cmd_o <= {1'b0, i > 2 && 1'($urandom), 5'($urandom)};
    end
  endtask : stay

  // clock never stops, so it is stable before cke rises
  task automatic leave(input int lock);
    @(posedge clk_i);
    cmd_o <= {2'b11, 5'($urandom)};
    odt_o <= 1'b0;
    des(EXIT_CYC + lock);
    odt_o <= 1'b1;
  endtask : leave
endmodule : sr_ctrl_model

// ---- sim/ddr4_self_refresh_sequencing_tb_top.sv ----
// Purpose: random and corner tests of self refresh entry, exit and registers
// Assumes: shortened timing parameters, controller model keeps its own rules
// Notes:   pulse outputs are counted by a monitor, not sampled at fixed cycles
`timescale 1ns/10ps
module ddr4_self_refresh_sequencing_tb_top;
  localparam int         LOCK = 16;
  localparam logic [2:0] RATES [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
  logic                  clk_i = 1'b0;
  logic                  rst_i = 1'b1;
  logic                  wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, last_fast = 1'b0, odt;
  logic [7:0]            wb_adr = 8'h00;
  logic [3:0]            wb_sel = 4'hF;
  logic [31:0]           wb_dat = 32'h0, rd, wb_dat_o;
  logic                  ack, odt_on, dll_en, dll_rst, gate, int_ref, ref_p, ref_f;
  sr_pkg::cmd_s          cmd;
  int                    miscompares = 0, n_checks = 0, n_ref = 0, n_int = 0, n_rst = 0, nf, snap, r;

  always #2.5 clk_i = ~clk_i;

  sr_seq #(.EXIT_CYC(12), .DLL_LOCK_CYC(LOCK), .SR_TICK_CYC(16)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .odt_i(odt), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(ack), .odt_on_o(odt_on), .dll_en_o(dll_en), .dll_rst_o(dll_rst), .clk_gate_o(gate),
    .int_refresh_o(int_ref), .refresh_o(ref_p), .refresh_fast_o(ref_f));
  sr_ctrl_model #(.EXIT_CYC(12)) u_ctrl (.clk_i(clk_i), .cmd_o(cmd), .odt_o(odt));

  always @(posedge clk_i) begin
    if (ref_p === 1'b1) begin
      n_ref <= n_ref + 1;
      last_fast <= ref_f;
    end
    if (int_ref === 1'b1) n_int <= n_int + 1;
    if (dll_rst === 1'b1) n_rst <= n_rst + 1;
  end
  // ----------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat} <= {2'b11, we, adr, dat};
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack !== 1'b1 && i < 20);
    rd = wb_dat_o;
    {wb_cyc, wb_stb} <= 2'b00;
    if (i >= 20) begin
      miscompares++;
      report_and_stop();
    end
  endtask : wb

  task automatic wait_st(input logic [31:0] st);
    for (int i = 0; i < 30; i++) begin
      wb(1'b0, sr_pkg::STATUS_OFS, 32'h0);
      if (rd === st) break;
    end
    chk("status", st, rd);
    if (rd !== st) report_and_stop();
  endtask : wait_st

  function automatic logic exp_fast(input logic [2:0] rt, input logic b);
    if (rt == sr_pkg::RATE_1X) return 1'b0;
    if (rt == sr_pkg::RATE_2X || rt == sr_pkg::RATE_4X) return 1'b1;
    return b;
  endfunction : exp_fast

  task automatic do_ref(input logic [2:0] rt, input logic bg);
    snap = n_ref;
    u_ctrl.refresh(bg);
    repeat (3) @(posedge clk_i);
    nf = exp_fast(rt, bg) ? nf + 1 : 0;
    chk("refresh", 32'(snap + 1), 32'(n_ref));
    chk("fast", {31'h0, exp_fast(rt, bg)}, {31'h0, last_fast});
  endtask : do_ref
  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [2:0] rate;
    logic       dll;
    logic       temperature_controlled_refresh;
    int         q;
    void'($urandom(32'hDD50660A));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, sr_pkg::CTRL_OFS, 32'h0);
    chk("ctrl", {27'h0, sr_pkg::CTRL_RST}, rd);
    wait_st(32'h1);
    wb_sel <= 4'hE;
    wb(1'b1, sr_pkg::CTRL_OFS, 32'h0000000F);
    wb_sel <= 4'hF;
    wb(1'b0, sr_pkg::CTRL_OFS, 32'h0);
    chk("ctrl masked", {27'h0, sr_pkg::CTRL_RST}, rd);
    wb(1'b1, 8'h0C, 32'hFFFFFFFF);
    wb(1'b0, 8'h0C, 32'h0);
    chk("unmapped", 32'h0, rd);
    for (int k = 0; k < 10; k++) begin
      rate = RATES[k % 5];
      dll = 1'($urandom);
      temperature_controlled_refresh = (rate == sr_pkg::RATE_1X) ? 1'($urandom) : 1'b0;
      q = (rate == sr_pkg::RATE_4X || rate == sr_pkg::RATE_OTF_4X) ? 4 : 2;
      nf = 0;
      wb(1'b1, sr_pkg::CTRL_OFS, {27'h0, dll, temperature_controlled_refresh, rate});
      wb(1'b0, sr_pkg::CTRL_OFS, 32'h0);
      chk("ctrl", {27'h0, dll, temperature_controlled_refresh, rate}, rd);
      repeat ($urandom_range(1, 5)) do_ref(rate, 1'($urandom));
      snap = n_int;
      r = n_ref;
      u_ctrl.enter();
      fork
        u_ctrl.stay(60);
        begin
          wait_st(32'h2);
          chk("odt in self", 32'h0, {31'h0, odt_on});
          chk("clock gate", 32'h1, {31'h0, gate});
          chk("dll in self", 32'h0, {31'h0, dll_en});
        end
      join
      chk("internal refresh", 32'h1, {31'h0, n_int > snap});
      snap = n_rst;
      fork
        u_ctrl.leave(LOCK);
        begin
          wait_st(32'h4);
          chk("refresh ignored", 32'(r), 32'(n_ref));
          chk("odt at exit", 32'h0, {31'h0, odt_on});
          wait_st(32'h8);
          chk("dll reset", {31'h0, dll}, 32'(n_rst - snap));
        end
      join
      wait_st(32'h1);
      chk("dll after", {31'h0, dll}, {31'h0, dll_en});
      chk("clock gate after", 32'h0, {31'h0, gate});
      if (rate != sr_pkg::RATE_1X && nf % q != 0)
        repeat (q) do_ref(rate, 1'b1);
      do_ref(rate, 1'b0);
      chk("odt after", 32'h1, {31'h0, odt_on});
      wb(1'b0, sr_pkg::COUNT_OFS, 32'h0);
      chk("entries", 32'(k + 1), rd);
    end
    report_and_stop();
  end
endmodule : ddr4_self_refresh_sequencing_tb_top
